// ---- logic/rtcsp_pkg.sv ----
`default_nettype none
package rtcsp_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int SYS_CLK_HZ     = 20_000_000;
    localparam int SYS_PERIOD_NS  = 50;
    localparam int SETUP_NS       = 31_000;
    localparam int SETUP_CYC      = (SETUP_NS + SYS_PERIOD_NS - 1)
                                    / SYS_PERIOD_NS;
    localparam int GAP_NS         = 61_000;
    localparam int GAP_CYC        = (GAP_NS + SYS_PERIOD_NS - 1)
                                    / SYS_PERIOD_NS;
    localparam int CE_MAX_MS      = 1000;
    localparam int CYC_PER_MS     = SYS_CLK_HZ / 1000;
    // 300 ns half period keeps the link under the 2 MHz ceiling
    localparam int SCLK_HALF_NS   = 300;
    localparam int HALF_CYC       = (SCLK_HALF_NS + SYS_PERIOD_NS - 1)
                                    / SYS_PERIOD_NS;
    localparam int GAP_W          = 11;
    localparam int HI_W           = 25;

    // ****************************************************************
    // command byte and transfer formats
    // ****************************************************************
    localparam int       BYTE_BITS      = 8;
    localparam int       CMD_ADDR_LSB   = 4;
    localparam logic [3:0] FMT_WR_ONE   = 4'h8;
    localparam logic [3:0] FMT_WR_BURST = 4'h0;
    localparam logic [3:0] FMT_RD_ONE   = 4'hc;
    localparam logic [3:0] FMT_RD_BURST = 4'h4;

    // ****************************************************************
    // device register map seen from outside
    // ****************************************************************
    localparam logic [3:0] ADDR_TIME_LAST  = 4'h6;
    localparam logic [3:0] ADDR_ALARM_MIN  = 4'hb;
    localparam logic [3:0] ADDR_ALARM_HOUR = 4'hc;
    localparam logic [7:0] ALARM_MIN_MASK  = 8'h7f;
    localparam logic [7:0] ALARM_HOUR_MASK = 8'h3f;
    localparam int         HOUR_PM_BIT     = 5;
    localparam logic [7:0] HOUR_MIDNIGHT_12H = 8'h12;
    localparam logic [7:0] HOUR_NOON_12H     = 8'h32;

    typedef enum logic [1:0] {
        op_wr_one,
        op_wr_burst,
        op_rd_one,
        op_rd_burst
    } rtcsp_op_e;

    typedef struct packed {
        logic [3:0] addr;
        rtcsp_op_e  op;
        logic [3:0] extra;  // burst: data bytes minus one
        logic       hold;   // single access only: keep chip enable high afterwards
    } rtcsp_cmd_s;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] data;
    } rtcsp_rd_s;

    function automatic logic [3:0] fmt_code(input rtcsp_op_e op);
        case (op)
            op_wr_one:   fmt_code = FMT_WR_ONE;
            op_wr_burst: fmt_code = FMT_WR_BURST;
            op_rd_one:   fmt_code = FMT_RD_ONE;
            default:     fmt_code = FMT_RD_BURST;
        endcase
    endfunction

    function automatic logic fmt_legal(input logic [3:0] code);
        fmt_legal = (code == FMT_WR_ONE) || (code == FMT_WR_BURST)
                 || (code == FMT_RD_ONE) || (code == FMT_RD_BURST);
    endfunction

    // plausibility of an alarm value before it is sent
    function automatic logic alarm_ok(input logic [3:0] addr,
                                      input logic [7:0] d,
                                      input logic       mode_12h);
        logic [1:0] tens;
        tens = d[5:4];
        alarm_ok = 1'b1;
        if (addr == ADDR_ALARM_MIN) begin
            alarm_ok = ((d & ~ALARM_MIN_MASK) == 8'h00)
                    && (d[3:0] <= 4'h9) && (d[6:4] <= 3'h5);
        end else if (addr == ADDR_ALARM_HOUR) begin
            if ((d & ~ALARM_HOUR_MASK) != 8'h00 || d[3:0] > 4'h9) begin
                alarm_ok = 1'b0;
            end else if (mode_12h) begin
                // midnight is 12h, noon 32h
                alarm_ok = (!d[4] && d[3:0] != 4'h0)
                        || (d[4] && d[3:0] <= 4'h2);
            end else begin
                alarm_ok = (tens < 2'h2) || (tens == 2'h2 && d[3:0] <= 4'h3);
            end
        end
    endfunction

endpackage
`default_nettype wire

// ---- logic/rtcsp_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module rtcsp_sync (
    input  wire logic i_sys_clk,  // system clock
    input  wire logic i_arst_n,   // async reset, active low
    input  wire logic i_pin,      // raw pin level
    output var  logic o_level     // filtered level
);

    logic q1;
    logic q2;
    logic q3;

    // ****************************************************************
    // three stages; a change counts once stages two and three agree
    // ****************************************************************
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q1 <= 1'b0;
            q2 <= 1'b0;
            q3 <= 1'b0;
        end else begin
            q1 <= i_pin;
            q2 <= q1;
            q3 <= q2;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_level <= 1'b0;
        end else if (q2 == q3) begin
            o_level <= q3;
        end
    end

endmodule
`default_nettype wire

// ---- logic/rtcsp_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module rtcsp_host #(
    parameter int unsigned P_CE_MAX_CYC =
        rtcsp_pkg::CE_MAX_MS * rtcsp_pkg::CYC_PER_MS
) (
    input  wire logic               i_sys_clk,    // system clock 20 MHz
    input  wire logic               i_arst_n,     // async reset, low
    input  wire logic               i_sclk_high,  // idle clock level
    input  wire logic               i_mode_12h,   // alarm check mode
    input  wire logic               i_cmd_valid,  // command offered
    input  wire rtcsp_pkg::rtcsp_cmd_s i_cmd,     // command
    output var  logic               o_cmd_ready,  // command taken
    input  wire logic               i_wr_valid,   // write byte offered
    input  wire logic [7:0]         i_wr_data,    // write byte
    output var  logic               o_wr_ready,   // write byte taken
    output var  logic               o_rd_valid,   // read byte pulse
    output var  rtcsp_pkg::rtcsp_rd_s o_rd,       // read byte, address
    output var  logic               o_abort,      // session cut pulse
    output var  logic               o_alarm_warn, // bad alarm pulse
    output var  logic               o_ce,         // chip enable pin
    output var  logic               o_sclk,       // serial clock pin
    output var  logic               o_sio,        // data pin out
    output var  logic               o_sio_oe,     // data pin enable
    input  wire logic               i_sio         // data pin in
);

    typedef enum logic [2:0] {
        st_idle,
        st_setup,
        st_byte,
        st_data,
        st_cmd,
        st_end
    } rtcsp_state_e;

    localparam int HALF_W = 3;
    localparam logic [HALF_W-1:0] HALF_LAST =
        HALF_W'(rtcsp_pkg::HALF_CYC - 1);

    rtcsp_state_e             state;
    rtcsp_pkg::rtcsp_op_e     op;
    logic [3:0]               cur_addr;
    logic [3:0]               remaining;
    logic                     hold;
    logic                     is_cmd;
    logic                     idle_lvl;
    logic [7:0]               shreg;
    logic [HALF_W-1:0]        ph;
    logic                     half;
    logic [2:0]               bit_idx;
    logic                     rx_bit;
    logic                     sio_s;
    logic [rtcsp_pkg::GAP_W-1:0] lo_cnt;
    logic [rtcsp_pkg::HI_W-1:0]  hi_cnt;
    logic                     gap_ok;
    logic                     setup_ok;
    logic                     expired;
    logic                     op_rd;
    logic                     op_burst;
    logic [7:0]               rx_byte;

    rtcsp_sync u_sio_sync (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_pin     (i_sio),
        .o_level   (sio_s)
    );

    // ****************************************************************
    // session timers
    // ****************************************************************
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lo_cnt <= '0;
        end else if (o_ce) begin
            lo_cnt <= '0;
        end else if (!gap_ok) begin
            lo_cnt <= lo_cnt + 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hi_cnt <= '0;
        end else if (!o_ce) begin
            hi_cnt <= '0;
        end else begin
            hi_cnt <= hi_cnt + 1'b1;
        end
    end

    // counting from reset too, so the first session also sees the gap
    assign gap_ok   = lo_cnt >= rtcsp_pkg::GAP_W'(rtcsp_pkg::GAP_CYC);
    assign setup_ok = hi_cnt >= rtcsp_pkg::HI_W'(rtcsp_pkg::SETUP_CYC);
    // cut the session a cycle before the limit; a partial byte is lost
    assign expired  = hi_cnt >= rtcsp_pkg::HI_W'(P_CE_MAX_CYC - 1);
    assign op_rd    = (op == rtcsp_pkg::op_rd_one)
                   || (op == rtcsp_pkg::op_rd_burst);
    assign op_burst = (op == rtcsp_pkg::op_wr_burst)
                   || (op == rtcsp_pkg::op_rd_burst);
    assign rx_byte  = {shreg[6:0], rx_bit};

    // ****************************************************************
    // session sequencer and shifter
    // ****************************************************************
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state        <= st_idle;
            op           <= rtcsp_pkg::op_wr_one;
            cur_addr     <= 4'h0;
            remaining    <= 4'h0;
            hold         <= 1'b0;
            is_cmd       <= 1'b0;
            idle_lvl     <= 1'b0;
            shreg        <= 8'h00;
            ph           <= '0;
            half         <= 1'b0;
            bit_idx      <= 3'h0;
            rx_bit       <= 1'b0;
            o_cmd_ready  <= 1'b0;
            o_wr_ready   <= 1'b0;
            o_rd_valid   <= 1'b0;
            o_rd         <= '0;
            o_abort      <= 1'b0;
            o_alarm_warn <= 1'b0;
            o_ce         <= 1'b0;
            o_sclk       <= 1'b0;
            o_sio        <= 1'b0;
            o_sio_oe     <= 1'b0;
        end else begin
            o_rd_valid   <= 1'b0;
            o_abort      <= 1'b0;
            o_alarm_warn <= 1'b0;
            if (o_ce && expired && state != st_end) begin
                // enable drops on this edge so it never outlives the limit
                state       <= st_idle;
                o_ce        <= 1'b0;
                o_abort     <= 1'b1;
                o_cmd_ready <= 1'b0;
                o_wr_ready  <= 1'b0;
                o_sclk      <= idle_lvl;
                o_sio_oe    <= 1'b0;
            end else begin
                case (state)
                    st_idle: begin
                        if (o_cmd_ready && i_cmd_valid) begin
                            // edge mode is the clock level at enable rise;
                            // the clock pin is frozen on this edge
                            idle_lvl    <= o_sclk;
                            o_ce        <= 1'b1;
                            o_cmd_ready <= 1'b0;
                            op          <= i_cmd.op;
                            cur_addr    <= i_cmd.addr;
                            remaining   <= i_cmd.extra;
                            hold        <= i_cmd.hold;
                            state       <= st_setup;
                        end else begin
                            o_sclk      <= i_sclk_high;
                            o_cmd_ready <= gap_ok;
                        end
                    end
                    st_cmd: begin
                        if (i_cmd_valid) begin
                            o_cmd_ready <= 1'b0;
                            op          <= i_cmd.op;
                            cur_addr    <= i_cmd.addr;
                            remaining   <= i_cmd.extra;
                            hold        <= i_cmd.hold;
                            state       <= st_setup;
                        end
                    end
                    st_setup: begin
                        // single access above the time block needs no wait
                        if (setup_ok || (!op_burst
                            && cur_addr > rtcsp_pkg::ADDR_TIME_LAST)) begin
                            shreg    <= {cur_addr, rtcsp_pkg::fmt_code(op)};
                            o_sio    <= cur_addr[3];
                            o_sio_oe <= 1'b1;
                            is_cmd   <= 1'b1;
                            o_sclk   <= ~idle_lvl;
                            ph       <= '0;
                            half     <= 1'b0;
                            bit_idx  <= 3'h0;
                            state    <= st_byte;
                        end
                    end
                    st_data: begin
                        if (i_wr_valid) begin
                            if (!rtcsp_pkg::alarm_ok(cur_addr, i_wr_data,
                                                     i_mode_12h)) begin
                                o_alarm_warn <= 1'b1;
                            end
                            o_wr_ready <= 1'b0;
                            shreg      <= i_wr_data;
                            o_sio      <= i_wr_data[7];
                            o_sio_oe   <= 1'b1;
                            o_sclk     <= ~idle_lvl;
                            ph         <= '0;
                            half       <= 1'b0;
                            bit_idx    <= 3'h0;
                            state      <= st_byte;
                        end
                    end
                    st_byte: begin
                        if (ph != HALF_LAST) begin
                            ph <= ph + 1'b1;
                        end else if (!half) begin
                            // read bit: device drove it at the lead edge
                            ph     <= '0;
                            half   <= 1'b1;
                            rx_bit <= sio_s;
                            o_sclk <= idle_lvl;
                        end else if (bit_idx != 3'h7) begin
                            ph      <= '0;
                            half    <= 1'b0;
                            bit_idx <= bit_idx + 1'b1;
                            shreg   <= rx_byte;
                            o_sio   <= shreg[6];
                            o_sclk  <= ~idle_lvl;
                        end else begin
                            ph      <= '0;
                            half    <= 1'b0;
                            bit_idx <= 3'h0;
                            shreg   <= rx_byte;
                            if (is_cmd) begin
                                is_cmd <= 1'b0;
                                if (op_rd) begin
                                    // release the line on the same edge that starts the device driving
                                    o_sio_oe <= 1'b0;
                                    o_sclk   <= ~idle_lvl;
                                end else begin
                                    o_wr_ready <= 1'b1;
                                    state      <= st_data;
                                end
                            end else begin
                                if (op_rd) begin
                                    o_rd_valid <= 1'b1;
                                    o_rd       <= {cur_addr, rx_byte};
                                end
                                cur_addr <= cur_addr + 1'b1;
                                if (op_burst && remaining != 4'h0) begin
                                    remaining <= remaining - 1'b1;
                                    if (op_rd) begin
                                        o_sclk <= ~idle_lvl;
                                    end else begin
                                        o_wr_ready <= 1'b1;
                                        state      <= st_data;
                                    end
                                end else if (op_burst || !hold) begin
                                    state    <= st_end;
                                    o_sio_oe <= 1'b0;
                                end else begin
                                    o_sio_oe    <= 1'b0;
                                    o_cmd_ready <= 1'b1;
                                    state       <= st_cmd;
                                end
                            end
                        end
                    end
                    st_end: begin
                        o_ce     <= 1'b0;
                        o_sio_oe <= 1'b0;
                        o_sclk   <= idle_lvl;
                        state    <= st_idle;
                    end
                    default: begin
                        state <= st_idle;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n);

    logic       sclk_q;
    logic [3:0] edge_cnt;

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sclk_q   <= 1'b0;
            edge_cnt <= 4'h0;
        end else begin
            sclk_q <= o_sclk;
            if (!o_ce) begin
                edge_cnt <= 4'h0;
            end else if (o_sclk != sclk_q) begin
                edge_cnt <= edge_cnt + 1'b1;
            end
        end
    end

    property p_gap;
        $rose(o_ce) |-> lo_cnt >= rtcsp_pkg::GAP_W'(rtcsp_pkg::GAP_CYC);
    endproperty
    a_gap: assert property (p_gap) else $error("enable low too short");

    property p_time_setup;
        (state == st_byte && !is_cmd
         && cur_addr <= rtcsp_pkg::ADDR_TIME_LAST) |-> setup_ok;
    endproperty
    a_time_setup: assert property (p_time_setup)
        else $error("time register touched too early");

    property p_whole_bytes;
        $fell(o_ce) && !o_abort |-> edge_cnt == 4'h0;
    endproperty
    a_whole_bytes: assert property (p_whole_bytes)
        else $error("session ended mid byte");

    property p_ce_max;
        o_ce |-> hi_cnt < rtcsp_pkg::HI_W'(P_CE_MAX_CYC);
    endproperty
    a_ce_max: assert property (p_ce_max)
        else $error("enable high too long");

    property p_rd_release;
        (state == st_byte && !is_cmd && op_rd) |-> !o_sio_oe;
    endproperty
    a_rd_release: assert property (p_rd_release)
        else $error("host drives line during read data");

    property p_mode;
        $rose(o_ce) |-> o_sclk == $past(o_sclk) && idle_lvl == o_sclk;
    endproperty
    a_mode: assert property (p_mode)
        else $error("clock moved at enable rise");

    property p_cmd_byte;
        (state == st_byte && is_cmd && bit_idx == 3'h0 && !half && ph == '0)
        |-> rtcsp_pkg::fmt_legal(shreg[3:0]) && shreg[7:4] == cur_addr
            && o_sio == shreg[7] && o_sio_oe;
    endproperty
    a_cmd_byte: assert property (p_cmd_byte)
        else $error("bad command byte");

    property p_burst_end;
        (state == st_byte && !is_cmd && op_burst && remaining == 4'h0
         && bit_idx == 3'h7 && half && ph == HALF_LAST)
        |=> (state == st_end) ##1 !o_ce;
    endproperty
    a_burst_end: assert property (p_burst_end)
        else $error("burst not closed by enable");

    property p_idle_pins;
        !o_ce && !$fell(o_ce) |-> !o_sio_oe;
    endproperty
    a_idle_pins: assert property (p_idle_pins)
        else $error("line driven outside session");

    c_burst_rd: cover property (o_rd_valid && op_burst ##[1:200] o_rd_valid);
    c_chain: cover property (state == st_cmd ##[1:50] state == st_setup);
    c_abort: cover property (o_abort);
    c_warn: cover property (o_alarm_warn);

endmodule
`default_nettype wire

// ---- testbench/rtcsp_dev_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module rtcsp_dev_model (
    input  wire logic i_ce,     // chip enable
    input  wire logic i_sclk,   // serial clock
    input  wire logic i_sio,    // data line level
    output var  logic o_sio,    // data back
    output var  logic o_sio_oe  // high while reading out
);
    // ****
    // register file and shifter
    // ****
    logic [7:0] regs [16];
    logic [7:0] sh;
    logic [3:0] ptr;
    logic [3:0] fmt;
    logic [2:0] cnt;
    logic       cmd_ph;
    logic       mode;
    initial begin
        foreach (regs[i]) regs[i] = 8'ha5;
        regs[11] = 8'h25;
        regs[12] = 8'h25;
        {o_sio, o_sio_oe, mode, cnt, cmd_ph, ptr, fmt, sh} = '0;
    end
    always @(posedge i_ce) begin
        mode = i_sclk;
        cnt = 3'h0;
        cmd_ph = 1'b1;
    end
    // a released line shows the inverse, never a stale bit
    // held carries would land here; no time digits are modelled
    always @(negedge i_ce) begin
        o_sio_oe = 1'b0;
        o_sio = ~o_sio;
    end
    always @(i_sclk) begin
        if (i_ce && i_sclk != mode && !cmd_ph && fmt[2]) begin
            if (cnt == 3'h0) sh = regs[ptr];
            o_sio = sh[3'h7 - cnt];
            o_sio_oe = 1'b1;
        end else if (i_ce && i_sclk == mode) begin
            o_sio = ~o_sio;
            o_sio_oe = 1'b0;
            if (cmd_ph || !fmt[2]) sh = {sh[6:0], i_sio};
            cnt = cnt + 3'h1;
            if (cnt == 3'h0 && cmd_ph) begin
                {ptr, fmt} = sh;
                cmd_ph = 1'b0;
            end else if (cnt == 3'h0) begin
                if (!fmt[2]) regs[ptr] = sh & (ptr == 4'hb ? 8'h7f
                    : ptr == 4'hc ? 8'h3f : 8'hff);
                cmd_ph = fmt[3];
                ptr = ptr + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/test_rtcsp_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_rtcsp_host;
    // ****
    // harness
    // ****
    logic clk, rst_n, sclk_hi, cmd_valid, cmd_ready, wr_valid, wr_ready;
    logic rd_valid, abort, warn, ce, sclk, h_sio, h_oe, d_sio, d_oe;
    logic [7:0] wr_data;
    logic mode12;
    rtcsp_pkg::rtcsp_cmd_s cmd;
    rtcsp_pkg::rtcsp_rd_s rd;
    int miscompares, comparisons, warns, aborts, lo_n;
    rtcsp_host #(.P_CE_MAX_CYC(3000)) dut (.i_sys_clk(clk),
        .i_arst_n(rst_n), .i_sclk_high(sclk_hi), .i_mode_12h(mode12),
        .i_cmd_valid(cmd_valid), .i_cmd(cmd), .o_cmd_ready(cmd_ready),
        .i_wr_valid(wr_valid), .i_wr_data(wr_data), .o_wr_ready(wr_ready),
        .o_rd_valid(rd_valid), .o_rd(rd), .o_abort(abort),
        .o_alarm_warn(warn), .o_ce(ce), .o_sclk(sclk), .o_sio(h_sio),
        .o_sio_oe(h_oe), .i_sio(h_oe ? h_sio : d_sio));
    rtcsp_dev_model dev (.i_ce(ce), .i_sclk(sclk),
        .i_sio(h_oe ? h_sio : d_sio), .o_sio(d_sio), .o_sio_oe(d_oe));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic send_cmd(logic m, logic [3:0] a, rtcsp_pkg::rtcsp_op_e op,
                            logic [3:0] x, logic h);
        @(posedge clk);
        sclk_hi <= m;
        cmd_valid <= 1'b1;
        cmd <= '{addr: a, op: op, extra: x, hold: h};
        for (int n = 0; n < 5000 && cmd_ready !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask
    task automatic send_byte(logic [7:0] d);
        @(posedge clk);
        wr_valid <= 1'b1;
        wr_data <= d;
        for (int n = 0; n < 3000 && wr_ready !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
        wr_valid <= 1'b0;
    endtask
    task automatic get_rd(logic [3:0] a, logic [7:0] d);
        for (int n = 0; n < 3000 && rd_valid !== 1'b1; n++) @(negedge clk);
        chk("read address and data", {a, d}, 16'(rd));
        @(negedge clk);
    endtask
    // low gaps between sessions let the device settle held carries
    always @(negedge clk) begin
        if (warn === 1'b1) warns++;
        if (abort === 1'b1) aborts++;
        if (d_oe === 1'b1) chk("line contention", 16'h0, 16'(h_oe));
        if (ce !== 1'b1) lo_n++;
        else if (lo_n != 0) begin
            chk("ce low gap", 16'h1, 16'(lo_n >= rtcsp_pkg::GAP_CYC));
            lo_n = 0;
        end
    end
    task automatic t_single_chain();
        send_cmd(1'b0, 4'hb, rtcsp_pkg::op_wr_one, 4'h0, 1'b1);
        send_byte(8'hd9);
        send_cmd(1'b0, 4'hb, rtcsp_pkg::op_rd_one, 4'h0, 1'b0);
        get_rd(4'hb, 8'h59);
    endtask
    task automatic t_burst_wrap();
        logic [7:0] wd [6] = '{8'hd9, 8'hf2, 8'h11, 8'h22, 8'h33, 8'h44};
        logic [7:0] ex [6] = '{8'h59, 8'h32, 8'h11, 8'h22, 8'h33, 8'h44};
        send_cmd(1'b1, 4'hb, rtcsp_pkg::op_wr_burst, 4'h5, 1'b0);
        foreach (wd[i]) send_byte(wd[i]);
        send_cmd(1'b1, 4'hb, rtcsp_pkg::op_rd_burst, 4'h5, 1'b0);
        foreach (ex[i]) get_rd(4'hb + 4'(i), ex[i]);
    endtask
    // 24-hour midnight is legal; a burst left unfed must be cut
    task automatic t_cut();
        @(posedge clk);
        mode12 <= 1'b0;
        send_cmd(1'b0, 4'hc, rtcsp_pkg::op_wr_one, 4'h0, 1'b1);
        send_byte(8'h00);
        send_cmd(1'b0, 4'h0, rtcsp_pkg::op_wr_burst, 4'h3, 1'b0);
        for (int n = 0; n < 4000 && abort !== 1'b1; n++) @(negedge clk);
        chk("watchdog cut", 16'h1, 16'(abort));
    endtask
    task automatic wrap_up();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        {rst_n, sclk_hi, cmd_valid, wr_valid, wr_data, cmd} = '0;
        {miscompares, comparisons, warns, aborts, lo_n} = '0;
        mode12 = 1'b1;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_single_chain();
        t_burst_wrap();
        t_cut();
        repeat (10) @(negedge clk);
        chk("alarm warnings", 16'h3, 16'(warns));
        chk("session aborts", 16'h1, 16'(aborts));
        wrap_up();
    end
    initial begin
        #2_000_000;
        miscompares++;
        wrap_up();
    end
endmodule
`default_nettype wire
